// ===== shared/fesf_pkg.sv
// Package with register map, field positions and mode codes for the FIFO error flags
package fesf_pkg;
	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_ERR_STATUS = 8'h04;
	localparam logic [7:0] OFS_ERR_SRC    = 8'h08;
	localparam logic [7:0] OFS_GEN_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;

	// -----------------------------------------------------------------
	// Control fields
	// -----------------------------------------------------------------
	localparam int CTL_MODE_LSB     = 16;
	localparam int CTL_WR_ERR_IE    = 14;
	localparam int CTL_RD_ERR_IE    = 13;
	localparam int CTL_WMARK_LSB    = 0;
	localparam logic [31:0] CTL_WMASK   = 32'h0007_60FF;
	localparam logic [31:0] CTL_RESET   = 32'h0000_0000;

	// -----------------------------------------------------------------
	// Error status fields
	// -----------------------------------------------------------------
	localparam int ST_SUMMARY   = 2;
	localparam int ST_STORE_ERR = 1;
	localparam int ST_FETCH_ERR = 0;
	localparam int GEN_SUMMARY  = 0;

	// -----------------------------------------------------------------
	// Interrupt status bits
	// -----------------------------------------------------------------
	localparam int IRQ_STORE = 0;
	localparam int IRQ_FETCH = 1;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

	typedef enum logic [1:0] {
		FESF_MODE_OFF    = 2'h0,
		FESF_MODE_WMARK  = 2'h1,
		FESF_MODE_STREAM = 2'h2
	} fesf_mode_t;
endpackage

// ===== hw/fesf_flags.sv
// Error flag core: store-fail, fetch-fail and summary flags
`timescale 1ns/100ps
module fesf_flags (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Mode and watermark
	input  wire logic [1:0] mode,
	input  wire logic [7:0] watermark,
	// FIFO events
	input  wire logic       conv_valid,
	input  wire logic       conv_writing,
	input  wire logic       host_rd_req,
	input  wire logic       host_rd_busy,
	input  wire logic       fifo_empty,
	input  wire logic [8:0] fifo_level,
	input  wire logic [5:0] other_err,
	// Flags
	output logic            store_err,
	output logic            fetch_err,
	output logic            summary_err,
	output logic            store_drop,
	output logic            fetch_refuse
);
	logic       store_err_r;
	logic       fetch_err_r;
	logic       wm_full_r;
	logic       wm_full_nxt;
	logic       store_nxt;
	logic       fetch_nxt;
	logic [8:0] wm_count;

	wire active    = (mode == fesf_pkg::FESF_MODE_WMARK) ||
	                 (mode == fesf_pkg::FESF_MODE_STREAM);                     // [R11]
	wire wm_mode   = (mode == fesf_pkg::FESF_MODE_WMARK);
	wire wm_hit    = (fifo_level >= wm_count);

	// Watermark of zero means the whole FIFO
	assign wm_count = (watermark == 8'h00) ? 9'h100 : {1'b0, watermark};

	// Latched full stays until the host drains completely
	assign wm_full_nxt = !wm_mode ? 1'b0 :
	                     fifo_empty ? 1'b0 :
	                     (wm_full_r || wm_hit);                                // [R4]

	assign store_drop   = active && conv_valid &&
	                      (host_rd_busy || (wm_mode && (wm_full_r || wm_hit))); // [R3] [R5]
	assign fetch_refuse = active && host_rd_req && conv_writing;               // [R8]

	// Set beats clear when both occur together
	assign store_nxt = !active ? 1'b0 :
	                   store_drop ? 1'b1 :
	                   fifo_empty ? 1'b0 : store_err_r;                        // [R6]
	wire   fetch_ok  = host_rd_req && !conv_writing;
	assign fetch_nxt = !active ? 1'b0 :
	                   fetch_refuse ? 1'b1 :
	                   (fetch_ok || fifo_empty) ? 1'b0 : fetch_err_r;          // [R9]

	always_ff @(posedge core_clk) begin
		if (rst) begin
			store_err_r <= 1'b0;                                               // [R14]
			fetch_err_r <= 1'b0;
			wm_full_r   <= 1'b0;
		end else begin
			store_err_r <= store_nxt;
			fetch_err_r <= fetch_nxt;
			wm_full_r   <= wm_full_nxt;
		end
	end

	assign store_err   = store_err_r;
	assign fetch_err   = fetch_err_r;
	assign summary_err = store_err_r || fetch_err_r || (|other_err);           // [R1]
endmodule

// ===== hw/fesf_top.sv
// Top: AXI4-Lite register slave around the FIFO error flag core
//
// What this block does
// R1: Summary error flag is one whenever any error bit is set.
// R2: General status summary bit copies the FIFO summary flag.
// R3: Watermark mode: dropped conversion (read busy or watermark hit) sets store-fail.
// R4: Watermark mode: FIFO counts full from watermark until fully emptied.
// R5: Streaming mode: store-fail set only when a host read blocks the write.
// R6: Store-fail clears when the FIFO becomes empty, in both modes.
// R7: Store-fail interrupt follows the flag exactly, no separate latch.
// R8: Fetch-fail set when a host read is refused during a write.
// R9: Fetch-fail clears on a later granted read or an empty FIFO.
// R10: Fetch-fail interrupt follows the flag exactly.
// R11: Store-fail and fetch-fail flags rise only in watermark or streaming mode, never disabled.
// R12: Store-fail reaches the interrupt pin only with control bit 14 set.
// R13: Fetch-fail reaches the interrupt pin only with control bit 13 set.
// R14: Error flags are read-only, reset to zero, ignore writes.
`timescale 1ns/100ps
module fesf_top (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// FIFO events, same clock domain
	input  wire logic        conv_valid,
	input  wire logic        conv_writing,
	input  wire logic        host_rd_req,
	input  wire logic        host_rd_busy,
	input  wire logic        fifo_empty,
	input  wire logic [8:0]  fifo_level,
	input  wire logic [5:0]  other_err,
	// Flags and interrupts
	output logic             store_err_int,
	output logic             fetch_err_int,
	output logic             fifo_err_pin,
	output logic             irq
);
	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic [31:0] ctl_r;
	logic [1:0]  irq_st_r;
	logic [1:0]  irq_st_nxt;
	logic [1:0]  irq_mask_r;
	logic [7:0]  aw_addr_r;
	logic        aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        w_have_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	logic store_err;
	logic fetch_err;
	logic summary_err;
	logic store_drop;
	logic fetch_refuse;

	// -----------------------------------------------------------------
	// Flag core
	// -----------------------------------------------------------------
	// Mode and watermark act from the edge after the control write lands
	wire [1:0] ctl_mode   = ctl_r[fesf_pkg::CTL_MODE_LSB +: 2];
	wire [7:0] ctl_wmark  = ctl_r[fesf_pkg::CTL_WMARK_LSB +: 8];
	wire       ctl_st_ie  = ctl_r[fesf_pkg::CTL_WR_ERR_IE];
	wire       ctl_ft_ie  = ctl_r[fesf_pkg::CTL_RD_ERR_IE];

	fesf_flags u_flags (
		.core_clk     (core_clk),
		.rst          (rst),
		.mode         (ctl_mode),
		.watermark    (ctl_wmark),
		.conv_valid   (conv_valid),
		.conv_writing (conv_writing),
		.host_rd_req  (host_rd_req),
		.host_rd_busy (host_rd_busy),
		.fifo_empty   (fifo_empty),
		.fifo_level   (fifo_level),
		.other_err    (other_err),
		.store_err    (store_err),
		.fetch_err    (fetch_err),
		.summary_err  (summary_err),
		.store_drop   (store_drop),
		.fetch_refuse (fetch_refuse)
	);

	// -----------------------------------------------------------------
	// Interrupt routing
	// -----------------------------------------------------------------
	// Level straight from the flag so the line clears with it
	assign store_err_int = store_err;                                         // [R7]
	assign fetch_err_int = fetch_err;                                         // [R10]
	// Enables gate only the shared pin; the per-flag lines stay unmasked
	assign fifo_err_pin  = (store_err && ctl_st_ie) ||                        // [R12]
	                       (fetch_err && ctl_ft_ie);                          // [R13]

	// -----------------------------------------------------------------
	// Write channel
	// -----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Address and data may come in either order; each waits for the other
	wire       aw_take  = s_axi_awvalid && s_axi_awready;
	wire       w_take   = s_axi_wvalid && s_axi_wready;
	wire       wr_fire  = aw_have_r && w_have_r && !bvalid_r;
	wire [5:0] aw_idx   = aw_addr_r[7:2];
	wire       wr_ctl   = wr_fire && (aw_idx == fesf_pkg::OFS_CONTROL[7:2]);
	wire       wr_mask  = wr_fire && (aw_idx == fesf_pkg::OFS_IRQ_MASK[7:2]);
	wire       wr_ro    = wr_fire && ((aw_idx == fesf_pkg::OFS_ERR_STATUS[7:2]) ||
	                      (aw_idx == fesf_pkg::OFS_ERR_SRC[7:2]) ||
	                      (aw_idx == fesf_pkg::OFS_GEN_STATUS[7:2]) ||
	                      (aw_idx == fesf_pkg::OFS_IRQ_STATUS[7:2]));
	wire wr_known = wr_ctl || wr_mask || wr_ro;

	// Byte strobes widen to a bit mask; only writable control bits pass
	logic [31:0] bmask;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign bmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
		end
	endgenerate
	wire [31:0] ctl_wmask = bmask & fesf_pkg::CTL_WMASK;

	assign s_axi_awready = !aw_have_r;
	assign s_axi_wready  = !w_have_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_r <= 1'b0;
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// Response stands until the master takes it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= 2'h0;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Control and mask registers
	// -----------------------------------------------------------------
	// Status words are read-only; writes there are accepted and dropped
	wire [31:0] ctl_wr_val = (ctl_r & ~ctl_wmask) | (w_data_r & ctl_wmask);
	wire        mask_we    = wr_mask && w_strb_r[0];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctl_r <= fesf_pkg::CTL_RESET;
		end else if (wr_ctl) begin
			ctl_r <= ctl_wr_val;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_mask_r <= fesf_pkg::IRQ_MASK_RESET;
		end else if (mask_we) begin
			irq_mask_r <= w_data_r[1:0];
		end
	end

	// -----------------------------------------------------------------
	// Read channel
	// -----------------------------------------------------------------
	wire ar_take  = s_axi_arvalid && s_axi_arready;
	wire [5:0] ar_idx = s_axi_araddr[7:2];
	wire rd_ctl   = (ar_idx == fesf_pkg::OFS_CONTROL[7:2]);
	wire rd_est   = (ar_idx == fesf_pkg::OFS_ERR_STATUS[7:2]);
	wire rd_src   = (ar_idx == fesf_pkg::OFS_ERR_SRC[7:2]);
	wire rd_gen   = (ar_idx == fesf_pkg::OFS_GEN_STATUS[7:2]);
	wire rd_ist   = (ar_idx == fesf_pkg::OFS_IRQ_STATUS[7:2]);
	wire rd_msk   = (ar_idx == fesf_pkg::OFS_IRQ_MASK[7:2]);
	wire rd_known = rd_ctl || rd_est || rd_src || rd_gen || rd_ist || rd_msk;

	// Flag bits come from flops and the other_err input, so no write path can reach them
	logic [31:0] est_word;
	logic [31:0] gen_word;
	wire  [31:0] src_word = {26'h000_0000, other_err};
	wire  [31:0] ist_word = {30'h0000_0000, irq_st_r};
	wire  [31:0] msk_word = {30'h0000_0000, irq_mask_r};

	always_comb begin
		est_word                         = 32'h0000_0000;
		est_word[fesf_pkg::ST_SUMMARY]   = summary_err;
		est_word[fesf_pkg::ST_STORE_ERR] = store_err;                          // [R14]
		est_word[fesf_pkg::ST_FETCH_ERR] = fetch_err;
	end

	always_comb begin
		gen_word                        = 32'h0000_0000;
		gen_word[fesf_pkg::GEN_SUMMARY] = summary_err;                         // [R2]
	end

	// Unmapped offsets read zero alongside their error response
	wire [31:0] rd_word  = rd_ctl ? ctl_r :
	                       rd_est ? est_word :
	                       rd_src ? src_word :
	                       rd_gen ? gen_word :
	                       rd_ist ? ist_word :
	                       rd_msk ? msk_word : 32'h0000_0000;

	// One read in flight; the next address waits until the data is taken
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// Read data is captured at acceptance and held until taken
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= 2'h0;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Sticky event status, cleared by reading it
	// -----------------------------------------------------------------
	wire [1:0] ev;
	wire       clr = ar_take && rd_ist;

	assign ev[fesf_pkg::IRQ_STORE] = store_drop;                              // [R3]
	assign ev[fesf_pkg::IRQ_FETCH] = fetch_refuse;                            // [R8]

	// A new event in the clearing cycle survives the clear; otherwise an
	// event landing beside the read would be lost from both word and status
	genvar bi;
	generate
		for (bi = 0; bi < 2; bi++) begin : g_sticky
			assign irq_st_nxt[bi] = ev[bi] || (!clr && irq_st_r[bi]);
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_st_r <= 2'h0;
		end else begin
			irq_st_r <= irq_st_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Interrupt line
	// -----------------------------------------------------------------
	// Level, high while any unmasked event bit is set; reading status drops it
	assign irq = |(irq_st_r & irq_mask_r);
endmodule

// ===== testbench/fesf_props.sv
// Checker: port-level relations of the FIFO error flag block
`timescale 1ns/100ps
module fesf_props (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Watched ports
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        conv_valid,
	input wire logic        conv_writing,
	input wire logic        host_rd_req,
	input wire logic        fifo_empty,
	input wire logic        store_err_int,
	input wire logic        fetch_err_int,
	input wire logic        fifo_err_pin
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_drain;
		fifo_empty && !(host_rd_req && conv_writing);
	endsequence
	sequence s_grant;
		host_rd_req && !conv_writing;
	endsequence
	chk_store_cause: assert property ($rose(store_err_int) |-> $past(conv_valid))
		else $error("store flag rose without a conversion");
	chk_store_empty: assert property (fifo_empty && !conv_valid |=> !store_err_int)
		else $error("store flag kept after empty");
	chk_fetch_cause: assert property ($rose(fetch_err_int) |-> $past(host_rd_req && conv_writing))
		else $error("fetch flag rose without a refused read");
	chk_fetch_grant: assert property (s_grant |=> !fetch_err_int)
		else $error("fetch flag kept after granted read");
	chk_fetch_empty: assert property (s_drain |=> !fetch_err_int)
		else $error("fetch flag kept after empty");
	chk_pin_idle: assert property (!store_err_int && !fetch_err_int |-> !fifo_err_pin)
		else $error("pin high with no flag");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
endmodule
bind fesf_top fesf_props fesf_props_i (.core_clk(core_clk), .rst(rst),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .conv_valid(conv_valid),
	.conv_writing(conv_writing), .host_rd_req(host_rd_req), .fifo_empty(fifo_empty),
	.store_err_int(store_err_int), .fetch_err_int(fetch_err_int), .fifo_err_pin(fifo_err_pin));

// ===== testbench/fesf_fifo_model.sv
// Partner model: FIFO fill level seen by the flag logic
`timescale 1ns/100ps
module fesf_fifo_model (
	// Clock and reset
	input  wire logic  core_clk,
	input  wire logic  rst,
	// Events
	input  wire logic  push,
	input  wire logic  host_rd_req,
	input  wire logic  conv_writing,
	// Level
	output logic [8:0] fifo_level,
	output logic       fifo_empty
);
	logic grant;
	// Read is refused while a conversion is written
	assign grant = host_rd_req && !conv_writing && (fifo_level != 9'h000);
	assign fifo_empty = (fifo_level == 9'h000);
	always_ff @(posedge core_clk) begin
		if (rst) fifo_level <= 9'h000;
		else fifo_level <= fifo_level + {8'h00, push} - {8'h00, grant};
	end
endmodule

// ===== testbench/testbench.sv
// Testbench: register and event sequences for the FIFO error flag block
`timescale 1ns/100ps
module testbench;
	logic core_clk = 1'b0, rst = 1'b1, push = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic conv_valid = 1'b0, conv_writing = 1'b0, host_rd_req = 1'b0, host_rd_busy = 1'b0;
	logic fifo_empty, store_err_int, fetch_err_int, fifo_err_pin, irq;
	logic [8:0] fifo_level;
	logic [5:0] other_err = 6'h00;
	int err_total = 0, tests_run = 0, cyc = 0;
	fesf_top fesf_top_i (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.conv_valid(conv_valid), .conv_writing(conv_writing), .host_rd_req(host_rd_req),
		.host_rd_busy(host_rd_busy), .fifo_empty(fifo_empty), .fifo_level(fifo_level),
		.other_err(other_err), .store_err_int(store_err_int), .fetch_err_int(fetch_err_int),
		.fifo_err_pin(fifo_err_pin), .irq(irq));
	fesf_fifo_model fesf_fifo_model_i (.core_clk(core_clk), .rst(rst), .push(push),
		.host_rd_req(host_rd_req), .conv_writing(conv_writing), .fifo_level(fifo_level),
		.fifo_empty(fifo_empty));
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	task end_of_test;
		if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard, well above the roughly 130 cycles the sequence needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	task cmp_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		cmp_word({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		cmp_word({30'h0000_0000, bresp}, 32'h0000_0000);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		cmp_word(rdata, exp);
		cmp_word({30'h0000_0000, rresp}, {30'h0000_0000, resp});
	endtask
	// One-cycle event: {push, conv_valid, conv_writing, host_rd_req, host_rd_busy}
	task ev(input logic [4:0] e);
		@(posedge core_clk);
		{push, conv_valid, conv_writing, host_rd_req, host_rd_busy} <= e;
		@(posedge core_clk);
		{push, conv_valid, conv_writing, host_rd_req, host_rd_busy} <= 5'h00;
		@(posedge core_clk);
		#1;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h04, 32'h0000_0000, 2'h0);
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0000_0000, 2'h0);
		rd(8'hFC, 32'h0000_0000, 2'h2);
		other_err <= 6'h01;
		rd(8'h04, 32'h0000_0004, 2'h0);
		rd(8'h0C, 32'h0000_0001, 2'h0);
		other_err <= 6'h00;
		ev(5'h10);
		ev(5'h10);
		ev(5'h09);
		cmp_bit(store_err_int, 1'b0);
		ev(5'h06);
		cmp_bit(fetch_err_int, 1'b0);
		wr(8'h00, 32'h0002_6001);
		ev(5'h08);
		cmp_bit(store_err_int, 1'b0);
		ev(5'h09);
		cmp_bit(store_err_int, 1'b1);
		cmp_bit(fifo_err_pin, 1'b1);
		rd(8'h04, 32'h0000_0006, 2'h0);
		rd(8'h0C, 32'h0000_0001, 2'h0);
		ev(5'h06);
		cmp_bit(fetch_err_int, 1'b1);
		wr(8'h14, 32'h0000_0003);
		cmp_bit(irq, 1'b1);
		rd(8'h10, 32'h0000_0003, 2'h0);
		rd(8'h10, 32'h0000_0000, 2'h0);
		cmp_bit(irq, 1'b0);
		wr(8'h00, 32'h0002_2001);
		cmp_bit(fifo_err_pin, 1'b1);
		ev(5'h02);
		cmp_bit(fetch_err_int, 1'b0);
		cmp_bit(fifo_err_pin, 1'b0);
		cmp_bit(store_err_int, 1'b1);
		ev(5'h02);
		cmp_bit(store_err_int, 1'b0);
		wr(8'h00, 32'h0001_0004);
		repeat (3) ev(5'h10);
		ev(5'h08);
		cmp_bit(store_err_int, 1'b0);
		ev(5'h10);
		ev(5'h02);
		ev(5'h08);
		cmp_bit(store_err_int, 1'b1);
		rd(8'h04, 32'h0000_0006, 2'h0);
		repeat (3) ev(5'h02);
		cmp_bit(store_err_int, 1'b0);
		ev(5'h06);
		cmp_bit(fetch_err_int, 1'b0);
		cmp_bit(irq, 1'b1);
		rd(8'h10, 32'h0000_0003, 2'h0);
		end_of_test();
	end
endmodule
